// ### gated_event_counter_regs.vh
// Register map, field positions and codes of the gated event counter
`ifndef GATED_EVENT_COUNTER_REGS_VH
`define GATED_EVENT_COUNTER_REGS_VH

`define GEC_ADDR_W        8
`define GEC_DATA_W        32
`define GEC_NUM_CNT       2

// Byte offsets
`define GEC_OFF_CTRL      8'h00
`define GEC_OFF_CFG0      8'h04
`define GEC_OFF_CFG1      8'h08
`define GEC_OFF_CFG_PAIR  8'h0c
`define GEC_OFF_CNT0      8'h10
`define GEC_OFF_CNT1      8'h14
`define GEC_OFF_STATUS    8'h18

// Control: start bits at 0+n, stop bits at 4+n, clear bits at 8+n
`define GEC_CTRL_START    0
`define GEC_CTRL_STOP     4
`define GEC_CTRL_CLEAR    8

// Configuration fields
`define GEC_CFG_GATE_LSB  0
`define GEC_CFG_GATE_MSB  2
`define GEC_CFG_EDGE      3
`define GEC_CFG_TB_LSB    16
`define GEC_CFG_TB_MSB    31
`define GEC_CFG_RESET     32'h0000_0000

// Status: running at 0+n, armed-by-gate at 4+n, gate level at 8+n, source level at 12+n
`define GEC_ST_RUN        0
`define GEC_ST_TRIG       4
`define GEC_ST_GATE       8
`define GEC_ST_SRC        12

// Gate modes
`define GEC_GATE_NONE     3'h0
`define GEC_GATE_HIGH     3'h1
`define GEC_GATE_LOW      3'h2
`define GEC_GATE_RISE     3'h3
`define GEC_GATE_FALL     3'h4

`define GEC_RESP_OKAY     2'h0
`define GEC_RESP_SLVERR   2'h2

`endif

// ### gated_event_counter.v
// Two gated event/timebase counters behind an AXI4-Lite register slave
//
// What this block does
// - One config write can set up one counter, or both together.
// - Each qualifying transition on the source input counts as one event.
// - Edge select 0 counts rising source transitions, 1 counts falling ones.
// - Gate mode 0 ignores the gate and counts right after software start.
// - After start, mode 1 counts while gate high, mode 2 while gate low.
// - After start, mode 3 begins at first gate rise, mode 4 at first fall.
// - Positive timebase field counts internal timebase ticks; zero or negative counts source edges.
`timescale 1ns/10ps
`include "gated_event_counter_regs.vh"

module gated_event_counter (
    input  wire                     aclk,
    input  wire                     aresetn,
    input  wire [`GEC_ADDR_W-1:0]   s_axi_awaddr,
    input  wire                     s_axi_awvalid,
    output reg                      s_axi_awready,
    input  wire [`GEC_DATA_W-1:0]   s_axi_wdata,
    input  wire [3:0]               s_axi_wstrb,
    input  wire                     s_axi_wvalid,
    output reg                      s_axi_wready,
    output reg  [1:0]               s_axi_bresp,
    output reg                      s_axi_bvalid,
    input  wire                     s_axi_bready,
    input  wire [`GEC_ADDR_W-1:0]   s_axi_araddr,
    input  wire                     s_axi_arvalid,
    output reg                      s_axi_arready,
    output reg  [`GEC_DATA_W-1:0]   s_axi_rdata,
    output reg  [1:0]               s_axi_rresp,
    output reg                      s_axi_rvalid,
    input  wire                     s_axi_rready,
    input  wire [`GEC_NUM_CNT-1:0]  counter_source_input,
    input  wire [`GEC_NUM_CNT-1:0]  counter_gate_input
);

////////////////////////////////////////////////////////////////////////////////
// Write channel: address and data taken in either order, response after both

reg                     aw_held_reg;
reg                     w_held_reg;
reg [`GEC_ADDR_W-1:0]   awaddr_reg;
reg [`GEC_DATA_W-1:0]   wdata_reg;
reg [3:0]               wstrb_reg;
wire                    wr_do;
wire [`GEC_DATA_W-1:0]  wmask;
wire                    wr_mapped;

assign wr_do = aw_held_reg & w_held_reg & ~s_axi_bvalid;
assign wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
assign wr_mapped = (awaddr_reg[7:2] == `GEC_OFF_CTRL >> 2) ||
                   (awaddr_reg[7:2] == `GEC_OFF_CFG0 >> 2) ||
                   (awaddr_reg[7:2] == `GEC_OFF_CFG1 >> 2) ||
                   (awaddr_reg[7:2] == `GEC_OFF_CFG_PAIR >> 2);

always @(posedge aclk) begin
    if (!aresetn) begin
        aw_held_reg   <= 1'b0;
        w_held_reg    <= 1'b0;
        awaddr_reg    <= 8'h00;
        wdata_reg     <= 32'h0000_0000;
        wstrb_reg     <= 4'h0;
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        s_axi_bvalid  <= 1'b0;
        s_axi_bresp   <= `GEC_RESP_OKAY;
    end else begin
        s_axi_awready <= ~aw_held_reg & ~(s_axi_awvalid & s_axi_awready) & ~wr_do;
        s_axi_wready  <= ~w_held_reg & ~(s_axi_wvalid & s_axi_wready) & ~wr_do;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
        end
        if (wr_do) begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_mapped ? `GEC_RESP_OKAY : `GEC_RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

// Ready returns while a response waits; a held write is done only after bvalid clears
wire wr_ctrl = wr_do && awaddr_reg[7:2] == `GEC_OFF_CTRL >> 2;
wire wr_pair = wr_do && awaddr_reg[7:2] == `GEC_OFF_CFG_PAIR >> 2;
wire [`GEC_DATA_W-1:0] ctrl_w = wdata_reg & wmask;

////////////////////////////////////////////////////////////////////////////////
// Counter channels

wire [`GEC_DATA_W-1:0]  cfg_q   [0:`GEC_NUM_CNT-1];
wire [`GEC_DATA_W-1:0]  count_q [0:`GEC_NUM_CNT-1];
wire [`GEC_NUM_CNT-1:0] run_q;
wire [`GEC_NUM_CNT-1:0] trig_q;
wire [`GEC_NUM_CNT-1:0] gate_lvl;
wire [`GEC_NUM_CNT-1:0] src_lvl;

genvar n;
generate
    for (n = 0; n < `GEC_NUM_CNT; n = n + 1) begin : g_cnt
        reg  [2:0]              src_sync_reg;
        reg  [2:0]              gate_sync_reg;
        reg  [`GEC_DATA_W-1:0]  cfg_reg;
        reg  [`GEC_DATA_W-1:0]  count_reg;
        reg                     run_reg;
        reg                     trig_reg;
        reg  [15:0]             tb_cnt_reg;
        wire [2:0]              gate_mode;
        wire                    edge_fall;
        wire signed [15:0]      tb_div;
        wire                    use_tb;
        wire                    src_rise;
        wire                    src_fall;
        wire                    gate_rise;
        wire                    gate_fall;
        wire                    tb_tick;
        wire                    event_hit;
        reg                     gate_ok;
        wire                    wr_own;

        assign gate_mode = cfg_reg[`GEC_CFG_GATE_MSB:`GEC_CFG_GATE_LSB];
        assign edge_fall = cfg_reg[`GEC_CFG_EDGE];
        assign tb_div    = cfg_reg[`GEC_CFG_TB_MSB:`GEC_CFG_TB_LSB];
        assign use_tb    = tb_div > 16'sh0000;
        // Only stages 1 and 2 feed logic; stage 0 is the metastable catcher
        assign src_rise  = src_sync_reg[1] & ~src_sync_reg[2];
        assign src_fall  = ~src_sync_reg[1] & src_sync_reg[2];
        assign gate_rise = gate_sync_reg[1] & ~gate_sync_reg[2];
        assign gate_fall = ~gate_sync_reg[1] & gate_sync_reg[2];
        assign tb_tick   = use_tb && tb_cnt_reg == tb_div - 16'h0001;
        assign event_hit = use_tb ? tb_tick : (edge_fall ? src_fall : src_rise);
        assign wr_own    = wr_do && awaddr_reg[7:2] == ((`GEC_OFF_CFG0 >> 2) + n);

        always @* begin
            case (gate_mode)
                `GEC_GATE_NONE: gate_ok = 1'b1;
                `GEC_GATE_HIGH: gate_ok = gate_sync_reg[1];
                `GEC_GATE_LOW:  gate_ok = ~gate_sync_reg[1];
                `GEC_GATE_RISE: gate_ok = trig_reg;
                `GEC_GATE_FALL: gate_ok = trig_reg;
                default:        gate_ok = 1'b0;
            endcase
        end

        always @(posedge aclk) begin
            if (!aresetn) begin
                src_sync_reg  <= 3'h0;
                gate_sync_reg <= 3'h0;
                cfg_reg       <= `GEC_CFG_RESET;
                count_reg     <= 32'h0000_0000;
                run_reg       <= 1'b0;
                trig_reg      <= 1'b0;
                tb_cnt_reg    <= 16'h0000;
            end else begin
                src_sync_reg  <= {src_sync_reg[1:0], counter_source_input[n]};
                gate_sync_reg <= {gate_sync_reg[1:0], counter_gate_input[n]};
                if (wr_own || wr_pair) begin
                    cfg_reg <= (cfg_reg & ~wmask) | (wdata_reg & wmask);
                end
                // Timebase divider free-runs while the counter runs, whatever the gate
                if (!use_tb || !run_reg || tb_tick) begin
                    tb_cnt_reg <= 16'h0000;
                end else begin
                    tb_cnt_reg <= tb_cnt_reg + 16'h0001;
                end
                // Edge trigger arms once per start and then stays armed
                if (run_reg && !trig_reg &&
                    ((gate_mode == `GEC_GATE_RISE && gate_rise) ||
                     (gate_mode == `GEC_GATE_FALL && gate_fall))) begin
                    trig_reg <= 1'b1;
                end
                if (run_reg && gate_ok && event_hit) begin
                    count_reg <= count_reg + 32'h0000_0001;
                end
                if (wr_ctrl && ctrl_w[`GEC_CTRL_CLEAR + n]) begin
                    count_reg <= 32'h0000_0000;
                end
                if (wr_ctrl && ctrl_w[`GEC_CTRL_STOP + n]) begin
                    run_reg  <= 1'b0;
                    trig_reg <= 1'b0;
                end else if (wr_ctrl && ctrl_w[`GEC_CTRL_START + n]) begin
                    run_reg  <= 1'b1;
                    trig_reg <= 1'b0;
                end
            end
        end

        assign cfg_q[n]   = cfg_reg;
        assign count_q[n] = count_reg;
        assign run_q[n]   = run_reg;
        assign trig_q[n]  = trig_reg;
        assign gate_lvl[n] = gate_sync_reg[1];
        assign src_lvl[n]  = src_sync_reg[1];
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Read channel: data one cycle after the address is taken

reg [`GEC_DATA_W-1:0] rd_mux;
reg                   rd_ok;

always @* begin
    rd_mux = 32'h0000_0000;
    rd_ok  = 1'b1;
    case (s_axi_araddr[7:2])
        `GEC_OFF_CTRL >> 2:   rd_mux = {30'h0000_0000, run_q};
        `GEC_OFF_CFG0 >> 2:   rd_mux = cfg_q[0];
        `GEC_OFF_CFG1 >> 2:   rd_mux = cfg_q[1];
        `GEC_OFF_CNT0 >> 2:   rd_mux = count_q[0];
        `GEC_OFF_CNT1 >> 2:   rd_mux = count_q[1];
        `GEC_OFF_STATUS >> 2: rd_mux = {18'h00000, src_lvl, 2'h0, gate_lvl,
                                        2'h0, trig_q, 2'h0, run_q};
        default:              rd_ok = 1'b0;
    endcase
end

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b0;
        s_axi_rdata   <= 32'h0000_0000;
        s_axi_rresp   <= `GEC_RESP_OKAY;
    end else begin
        s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_ok ? `GEC_RESP_OKAY : `GEC_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b0;
        end
    end
end

endmodule // gated_event_counter

// ### counter_props.sv
// Bus handshake checker for the gated event counter
`timescale 1ns/10ps
module counter_props (
    input wire        aclk,
    input wire        aresetn,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("bresp unstable");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("rdata unstable");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read answer");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:6] s_axi_bvalid)
        else $error("no write answer");
    a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("bvalid kept");
    a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid
        ##[0:2] s_axi_arready) else $error("read not released");
    a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
        else $error("error read carries data");
    a_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready early");
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // counter_props
bind gated_event_counter counter_props counter_props_inst (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// ### pin_model.sv
// Model of the external event source and gate pins
`timescale 1ns/10ps
module pin_model (
    input  wire       aclk,
    output reg  [1:0] src,
    output reg  [1:0] gate
);
    initial begin
        src = 2'h0;
        gate = 2'h0;
    end
    // Four clocks per level, well above the one-clock minimum of the input sync
    task pulse(input integer n, input integer k);
        integer i;
        for (i = 0; i < k; i = i + 1) begin
            src[n] <= 1'b1;
            repeat (4) @(posedge aclk);
            src[n] <= 1'b0;
            repeat (4) @(posedge aclk);
        end
    endtask
endmodule // pin_model

// ### tb_top.sv
// Self-checking bench for the gated event counter
`timescale 1ns/10ps
`include "gated_event_counter_regs.vh"
module tb_top;
    reg         aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    reg         s_axi_arvalid, s_axi_rready;
    reg  [7:0]  s_axi_awaddr, s_axi_araddr;
    reg  [31:0] s_axi_wdata, rd_data;
    reg  [3:0]  s_axi_wstrb;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0]  s_axi_bresp, s_axi_rresp, src, gate;
    wire [31:0] s_axi_rdata;
    integer     n_fail, cmp_count, e;
    gated_event_counter gated_event_counter_inst (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .counter_source_input(src), .counter_gate_input(gate));
    pin_model pin_model_inst (.aclk, .src, .gate);
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task results; begin
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    end endtask
    task chk(input [31:0] got, input [31:0] exp); begin
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    end endtask
    // A hung handshake counts as a mismatch and ends the run
    task tmo(input integer i);
        if (i >= 60) begin
            n_fail = n_fail + 1;
            results;
        end
    endtask
    task wr(input [7:0] a, input [31:0] d, input [1:0] er);
        integer i;
        begin
            @(posedge aclk);
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
            for (i = 0; i < 60 && s_axi_bvalid !== 1'b1; i = i + 1) begin
                @(posedge aclk);
                if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
                if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            end
            s_axi_bready <= 1'b0;
            tmo(i);
            chk(s_axi_bresp, er);
        end
    endtask
    task rd(input [7:0] a, input [1:0] er);
        integer i;
        begin
            @(posedge aclk);
            s_axi_araddr <= a;
            {s_axi_arvalid, s_axi_rready} <= 2'h3;
            for (i = 0; i < 60 && s_axi_rvalid !== 1'b1; i = i + 1) begin
                @(posedge aclk);
                if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            end
            s_axi_rready <= 1'b0;
            rd_data = s_axi_rdata;
            tmo(i);
            chk(s_axi_rresp, er);
        end
    endtask
    // Two pulses under gate level g0, three more after the gate moves to g1
    task trial(input integer n, input [7:0] ca, input [31:0] cfg, input st, input g0,
               input g1, input [31:0] exp); begin
        wr(`GEC_OFF_CTRL, 32'h110 << n, 2'h0);
        pin_model_inst.gate[n] <= g0;
        wr(ca, cfg, 2'h0);
        wr(`GEC_OFF_CTRL, {31'h0, st} << n, 2'h0);
        pin_model_inst.pulse(n, 2);
        pin_model_inst.gate[n] <= g1;
        repeat (8) @(posedge aclk);
        pin_model_inst.pulse(n, 3);
        repeat (8) @(posedge aclk);
        wr(`GEC_OFF_CTRL, 32'h10 << n, 2'h0);
        rd(n ? `GEC_OFF_CNT1 : `GEC_OFF_CNT0, 2'h0);
        chk(rd_data, exp);
    end endtask
    ////////////////////////////////////////////////////////////////////////////////
    task sc_reset; begin
        rd(`GEC_OFF_CFG1, 2'h0);
        chk(rd_data, `GEC_CFG_RESET);
        rd(`GEC_OFF_STATUS, 2'h0);
        chk(rd_data, 32'h0);
        rd(8'h1c, 2'h2);
        chk(rd_data, 32'h0);
        wr(`GEC_OFF_CNT0, 32'h1, 2'h2);
    end endtask
    task sc_gate; begin
        trial(0, `GEC_OFF_CFG0, 32'h0, 1'b0, 1'b0, 1'b1, 32'h0);
        trial(0, `GEC_OFF_CFG0, 32'h0, 1'b1, 1'b0, 1'b1, 32'h5);
        trial(0, `GEC_OFF_CFG0, 32'h1, 1'b1, 1'b0, 1'b1, 32'h3);
        trial(0, `GEC_OFF_CFG0, 32'h2, 1'b1, 1'b0, 1'b1, 32'h2);
        trial(0, `GEC_OFF_CFG0, 32'h3, 1'b1, 1'b0, 1'b1, 32'h3);
        // Unused gate codes never let the counter move
        trial(0, `GEC_OFF_CFG0, 32'h5, 1'b1, 1'b0, 1'b1, 32'h0);
        trial(0, `GEC_OFF_CFG0, 32'h4, 1'b1, 1'b1, 1'b0, 32'h3);
    end endtask
    task sc_pair; begin
        trial(1, `GEC_OFF_CFG_PAIR, 32'hffff_0001, 1'b1, 1'b0, 1'b1, 32'h3);
        rd(`GEC_OFF_CFG0, 2'h0);
        chk(rd_data, 32'hffff_0001);
        // Only the low byte lane may land in the config word
        s_axi_wstrb <= 4'h1;
        wr(`GEC_OFF_CFG0, 32'h1234_5678, 2'h0);
        s_axi_wstrb <= 4'hf;
        rd(`GEC_OFF_CFG0, 2'h0);
        chk(rd_data, 32'hffff_0078);
        // Gate of counter 1 was left high; both counters stopped and disarmed
        rd(`GEC_OFF_STATUS, 2'h0);
        chk(rd_data, 32'h0000_0200);
    end endtask
    task sc_edge;
        for (e = 0; e < 2; e = e + 1) begin
            wr(`GEC_OFF_CTRL, 32'h100, 2'h0);
            wr(`GEC_OFF_CFG0, e << 3, 2'h0);
            wr(`GEC_OFF_CTRL, 32'h1, 2'h0);
            pin_model_inst.src[0] <= 1'b1;
            repeat (8) @(posedge aclk);
            rd(`GEC_OFF_CNT0, 2'h0);
            chk(rd_data, 1 - e);
            pin_model_inst.src[0] <= 1'b0;
            repeat (8) @(posedge aclk);
            rd(`GEC_OFF_CNT0, 2'h0);
            chk(rd_data, 32'h1);
            wr(`GEC_OFF_CTRL, 32'h10, 2'h0);
        end
    endtask
    // Tick every 4 clocks over 40 clocks; bus latency leaves a small spread
    task sc_timebase; begin
        wr(`GEC_OFF_CTRL, 32'h100, 2'h0);
        wr(`GEC_OFF_CFG0, 32'h0004_0000, 2'h0);
        wr(`GEC_OFF_CTRL, 32'h1, 2'h0);
        repeat (40) @(posedge aclk);
        wr(`GEC_OFF_CTRL, 32'h10, 2'h0);
        rd(`GEC_OFF_CNT0, 2'h0);
        chk(rd_data >= 32'h8 && rd_data <= 32'hc, 32'h1);
    end endtask
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hf;
        n_fail = 0;
        cmp_count = 0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        sc_reset;
        sc_gate;
        sc_pair;
        sc_edge;
        sc_timebase;
        results;
    end
endmodule // tb_top
